// [shared/pcp_regs.svh]
`ifndef PCP_REGS_SVH
`define PCP_REGS_SVH

// ****************************************
// format and pattern encodings
// ****************************************
`define PCP_FMT_720P60 2'h0
`define PCP_FMT_1080P60 2'h1
`define PCP_FMT_2160P30 2'h2
`define PCP_FMT_2160P60 2'h3
`define PCP_PAT_BARS 2'h0
`define PCP_PAT_ZONE 2'h1
`define PCP_PAT_RAMP 2'h2
`define PCP_PAT_BOX 2'h3

// ****************************************
// stream layout
// ****************************************
`define PCP_PPC 13'h2
`define PCP_PAD 8'h00
`define PCP_CHROMA_MID 8'h80
`define PCP_ADDR_STEP 32'h4
`define PCP_BOX_SIZE 13'h40
`define PCP_BOX_HI 8'hEB
`define PCP_BOX_LO 8'h10

// ****************************************
// line and frame timing, in pixels and lines
// ****************************************
`define PCP_720_HACT 13'h500
`define PCP_720_HFP 13'h06E
`define PCP_720_HSYNC 13'h028
`define PCP_720_HBP 13'h0DC
`define PCP_720_VACT 12'h2D0
`define PCP_720_VFP 12'h005
`define PCP_720_VSYNC 12'h005
`define PCP_720_VBP 12'h014
`define PCP_1080_HACT 13'h780
`define PCP_1080_HFP 13'h058
`define PCP_1080_HSYNC 13'h02C
`define PCP_1080_HBP 13'h094
`define PCP_1080_VACT 12'h438
`define PCP_1080_VFP 12'h004
`define PCP_1080_VSYNC 12'h005
`define PCP_1080_VBP 12'h024
`define PCP_2160_HACT 13'hF00
`define PCP_2160_HFP 13'h0B0
`define PCP_2160_HSYNC 13'h058
`define PCP_2160_HBP 13'h128
`define PCP_2160_VACT 12'h870
`define PCP_2160_VFP 12'h008
`define PCP_2160_VSYNC 12'h00A
`define PCP_2160_VBP 12'h048

// ****************************************
// pixel clock requests, in kHz
// ****************************************
`define PCP_CLK_720P60 20'h1220A
`define PCP_CLK_1080P60 20'h24414
`define PCP_CLK_2160P30 20'h48828
`define PCP_CLK_2160P60 20'h91050

`endif

// [shared/pcp_pkg.sv]
`default_nettype none
package pcp_pkg;
`include "pcp_regs.svh"

   typedef enum logic [1:0] {
      PCP_FMT_720P60 = `PCP_FMT_720P60,
      PCP_FMT_1080P60 = `PCP_FMT_1080P60,
      PCP_FMT_2160P30 = `PCP_FMT_2160P30,
      PCP_FMT_2160P60 = `PCP_FMT_2160P60
   } pcp_format_t;

   typedef enum logic [1:0] {
      PCP_PAT_BARS = `PCP_PAT_BARS,
      PCP_PAT_ZONE = `PCP_PAT_ZONE,
      PCP_PAT_RAMP = `PCP_PAT_RAMP,
      PCP_PAT_BOX = `PCP_PAT_BOX
   } pcp_pattern_t;

   typedef struct packed {
      logic [12:0] h_act;
      logic [12:0] h_fp;
      logic [12:0] h_sync;
      logic [12:0] h_bp;
      logic [11:0] v_act;
      logic [11:0] v_fp;
      logic [11:0] v_sync;
      logic [11:0] v_bp;
   } pcp_timing_t;

   // one stream beat: two 24-bit pixel slots
   typedef struct packed {
      logic sof;
      logic eol;
      logic [47:0] data;
   } pcp_beat_t;

   typedef struct packed {
      logic hsync;
      logic vsync;
      logic hblank;
      logic vblank;
      logic active;
   } pcp_sync_t;

   // timing table; 2160p60 shares 2160p30 lines at twice the clock
   function automatic pcp_timing_t pcp_timing(input pcp_format_t f);
      pcp_timing_t t;
      case (f)
         PCP_FMT_720P60: t = {`PCP_720_HACT, `PCP_720_HFP,
            `PCP_720_HSYNC, `PCP_720_HBP, `PCP_720_VACT, `PCP_720_VFP,
            `PCP_720_VSYNC, `PCP_720_VBP};
         PCP_FMT_1080P60: t = {`PCP_1080_HACT, `PCP_1080_HFP,
            `PCP_1080_HSYNC, `PCP_1080_HBP, `PCP_1080_VACT,
            `PCP_1080_VFP, `PCP_1080_VSYNC, `PCP_1080_VBP};
         default: t = {`PCP_2160_HACT, `PCP_2160_HFP,
            `PCP_2160_HSYNC, `PCP_2160_HBP, `PCP_2160_VACT,
            `PCP_2160_VFP, `PCP_2160_VSYNC, `PCP_2160_VBP};
      endcase
      return t;
   endfunction

endpackage
`default_nettype wire

// [rtl/pcp_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module pcp_fifo #(
   parameter int WIDTH = 50,
   parameter int DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic flush_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] count_q;
   logic push;
   logic pop;

   // array holds DEPTH words, the output register one more
   assign in_ready_out = (count_q != (AW+1)'(DEPTH));
   assign push = in_valid_in && in_ready_out;
   assign pop = (count_q != '0) && (!out_valid_out || out_ready_in);

   // storage array, no reset needed
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_in;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else if (flush_in) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
         end
         if (pop) begin
            rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
         end
         count_q <= (AW+1)'(count_q + push - pop);
      end
   end

   // registered read data, so the drain side sees flop outputs
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         out_valid_out <= 1'b0;
         out_data_out <= '0;
      end else if (flush_in) begin
         out_valid_out <= 1'b0;
      end else if (pop) begin
         out_valid_out <= 1'b1;
         out_data_out <= mem_q[rd_ptr_q];
      end else if (out_ready_in) begin
         out_valid_out <= 1'b0;
      end
   end
endmodule // pcp_fifo
`default_nettype wire

// [rtl/pcp_pipeline.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pcp_regs.svh"
module pcp_pipeline #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire pcp_pkg::pcp_format_t format_in,
   input wire pcp_pkg::pcp_pattern_t pattern_in,
   input wire logic core_reset_in,
   input wire logic [31:0] frame_base_in,
   input wire logic mem_wr_ready_in,
   output pcp_pkg::pcp_sync_t sync_out,
   output logic [19:0] pix_clk_khz_out,
   output logic mem_wr_valid_out,
   output logic [31:0] mem_wr_addr_out,
   output logic [31:0] mem_wr_data_out,
   output logic mem_wr_last_out,
   output logic frame_done_out
);
   import pcp_pkg::*;

   // ****************************************
   // pattern helpers
   // ****************************************

   // colour bar table as {y, u, v}
   function automatic logic [23:0] bar_yuv(input logic [2:0] bar);
      logic [23:0] c;
      case (bar)
         3'h0: c = 24'hEB8080;
         3'h1: c = 24'hD21092;
         3'h2: c = 24'hAAA610;
         3'h3: c = 24'h913622;
         3'h4: c = 24'h6ACADE;
         3'h5: c = 24'h515AF0;
         3'h6: c = 24'h29F06E;
         default: c = 24'h108080;
      endcase
      return c;
   endfunction

   // luma of one pixel; called once per slot
   function automatic logic [7:0] pat_luma(input pcp_pattern_t p,
         input logic [12:0] x, input logic [11:0] y,
         input logic [7:0] fc);
      logic [25:0] rr;
      logic [12:0] dx;
      logic [12:0] dy;
      logic [23:0] c;
      rr = 26'(x) * 26'(x) + 26'(y) * 26'(y);
      dx = x - {3'h0, fc, 2'h0};
      dy = {1'b0, y} - {3'h0, fc, 2'h0};
      c = bar_yuv(x[11:9]);
      case (p)
         PCP_PAT_BARS: pat_luma = c[23:16];
         PCP_PAT_ZONE: pat_luma = rr[15:8]; // static rings; fc unused
         PCP_PAT_RAMP: pat_luma = 8'(x[7:0] + fc);
         PCP_PAT_BOX: pat_luma = (dx < `PCP_BOX_SIZE &&
            dy < `PCP_BOX_SIZE) ? `PCP_BOX_HI : `PCP_BOX_LO;
         default: pat_luma = `PCP_BOX_LO;
      endcase
   endfunction

   // ****************************************
   // timing generator
   // ****************************************
   pcp_format_t fmt_q;
   pcp_timing_t tm;
   logic [12:0] h_q;
   logic [11:0] v_q;
   logic [12:0] h_total;
   logic [11:0] v_total;
   logic [12:0] hs_beg;
   logic [12:0] hs_end;
   logic [11:0] vs_beg;
   logic [11:0] vs_end;
   logic h_last;
   logic v_last;
   pcp_sync_t sync_d;
   logic adv;
   logic fifo_in_ready;

   // line and frame geometry of the current format
   always_comb begin
      tm = pcp_timing(fmt_q);
      h_total = tm.h_act + tm.h_fp + tm.h_sync + tm.h_bp;
      v_total = tm.v_act + tm.v_fp + tm.v_sync + tm.v_bp;
      hs_beg = tm.h_act + tm.h_fp;
      hs_end = hs_beg + tm.h_sync;
      vs_beg = tm.v_act + tm.v_fp;
      vs_end = vs_beg + tm.v_sync;
      h_last = (h_q == h_total - `PCP_PPC);
      v_last = (v_q == v_total - 12'h1);
   end

   // active first, then front porch, sync and back porch
   always_comb begin
      sync_d.hblank = (h_q >= tm.h_act);
      sync_d.vblank = (v_q >= tm.v_act);
      sync_d.hsync = (h_q >= hs_beg) && (h_q < hs_end);
      sync_d.vsync = (v_q >= vs_beg) && (v_q < vs_end);
      sync_d.active = !sync_d.hblank && !sync_d.vblank;
   end

   logic pg_valid_q;
   // a full fifo stalls the raster, so no pixel is dropped outside a core reset
   assign adv = !(pg_valid_q && !fifo_in_ready);

   // raster counters; a format change restarts the frame
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         fmt_q <= PCP_FMT_720P60;
         h_q <= '0;
         v_q <= '0;
      end else if (fmt_q != format_in) begin
         fmt_q <= format_in;
         h_q <= '0;
         v_q <= '0;
      end else if (adv) begin
         h_q <= h_last ? '0 : h_q + `PCP_PPC;
         if (h_last) begin
            v_q <= v_last ? '0 : v_q + 12'h1;
         end
      end
   end

   // registered sync outputs
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sync_out <= '0;
      end else if (adv) begin
         sync_out <= sync_d;
      end
   end

   // pixel clock request for the clock synthesizer
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pix_clk_khz_out <= `PCP_CLK_720P60;
      end else begin
         case (fmt_q)
            PCP_FMT_720P60: pix_clk_khz_out <= `PCP_CLK_720P60;
            PCP_FMT_1080P60: pix_clk_khz_out <= `PCP_CLK_1080P60;
            PCP_FMT_2160P30: pix_clk_khz_out <= `PCP_CLK_2160P30;
            default: pix_clk_khz_out <= `PCP_CLK_2160P60;
         endcase
      end
   end

   // ****************************************
   // timing stream, data tied off
   // ****************************************
   pcp_beat_t tm_beat;
   logic tm_valid;

   always_comb begin
      tm_valid = sync_d.active;
      tm_beat.sof = tm_valid && (h_q == '0) && (v_q == '0);
      tm_beat.eol = tm_valid && (h_q == tm.h_act - `PCP_PPC);
      tm_beat.data = '0;
   end

   // ****************************************
   // pattern generator
   // ****************************************
   pcp_beat_t pg_q;
   logic [7:0] fc_q;
   logic [7:0] luma0;
   logic [7:0] luma1;
   logic [7:0] cb;
   logic [7:0] cr;
   logic [23:0] bar_c;

   // chroma shared by the pixel pair, as 4:2:2 requires
   always_comb begin
      luma0 = pat_luma(pattern_in, h_q, v_q, fc_q);
      luma1 = pat_luma(pattern_in, h_q + 13'h1, v_q, fc_q);
      bar_c = bar_yuv(h_q[11:9]);
      cb = (pattern_in == PCP_PAT_BARS) ? bar_c[15:8] : `PCP_CHROMA_MID;
      cr = (pattern_in == PCP_PAT_BARS) ? bar_c[7:0] : `PCP_CHROMA_MID;
   end

   // motion counter, stepped once per frame
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         fc_q <= '0;
      end else if (core_reset_in) begin
         fc_q <= '0;
      end else if (adv && h_last && v_last) begin
         fc_q <= fc_q + 8'h1;
      end
   end

   // beats exist only where the timing stream has one
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pg_valid_q <= 1'b0;
         pg_q <= '0;
      end else if (core_reset_in) begin
         pg_valid_q <= 1'b0;
      end else if (adv) begin
         pg_valid_q <= tm_valid;
         pg_q.sof <= tm_beat.sof;
         pg_q.eol <= tm_beat.eol;
         // slot 0 low: pad, cb, luma; slot 1 high: pad, cr, luma
         pg_q.data <= {`PCP_PAD, cr, luma1, `PCP_PAD, cb, luma0};
      end
   end

   // ****************************************
   // buffer between pattern and frame writer
   // ****************************************
   logic fifo_out_valid;
   logic [$bits(pcp_beat_t)-1:0] fifo_out_data;
   pcp_beat_t fb;
   logic wr_load;

   pcp_fifo #(
      .WIDTH($bits(pcp_beat_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .flush_in(core_reset_in),
      .in_valid_in(pg_valid_q),
      .in_ready_out(fifo_in_ready),
      .in_data_in(pg_q),
      .out_valid_out(fifo_out_valid),
      .out_ready_in(wr_load),
      .out_data_out(fifo_out_data)
   );

   assign fb = pcp_beat_t'(fifo_out_data);

   // ****************************************
   // frame writer
   // ****************************************
   logic [31:0] next_addr_q;
   logic [11:0] line_q;
   logic [31:0] beat_addr;
   logic [11:0] beat_line;
   logic beat_eof;
   pcp_timing_t wtm;

   // output stage refills when empty or when memory takes its word
   assign wr_load = !mem_wr_valid_out || mem_wr_ready_in;

   // placement of the beat in the frame
   always_comb begin
      wtm = pcp_timing(fmt_q);
      beat_addr = fb.sof ? frame_base_in : next_addr_q;
      beat_line = fb.sof ? '0 : line_q;
      beat_eof = fb.eol && (beat_line == wtm.v_act - 12'h1);
   end

   // memory write stage
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         mem_wr_valid_out <= 1'b0;
         mem_wr_addr_out <= '0;
         mem_wr_data_out <= '0;
         mem_wr_last_out <= 1'b0;
      end else if (core_reset_in) begin
         mem_wr_valid_out <= 1'b0;
      end else if (wr_load) begin
         mem_wr_valid_out <= fifo_out_valid;
         mem_wr_addr_out <= beat_addr;
         // word holds luma0, cb, luma1, cr from low byte up
         mem_wr_data_out <= {fb.data[39:24], fb.data[15:0]};
         mem_wr_last_out <= beat_eof;
      end
   end

   // address and line tracking
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         next_addr_q <= '0;
         line_q <= '0;
      end else if (core_reset_in) begin
         line_q <= '0;
      end else if (wr_load && fifo_out_valid) begin
         next_addr_q <= beat_addr + `PCP_ADDR_STEP;
         if (fb.eol) begin
            line_q <= beat_eof ? '0 : beat_line + 12'h1;
         end else begin
            line_q <= beat_line;
         end
      end
   end

   // one pulse when the last word of a frame is taken
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         frame_done_out <= 1'b0;
      end else begin
         frame_done_out <= !core_reset_in && mem_wr_valid_out &&
            mem_wr_ready_in && mem_wr_last_out;
      end
   end
endmodule // pcp_pipeline
`default_nettype wire

// [sim/pcp_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ********
// memory port partner
// ********
module pcp_mem_model (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [6:0] ready_pct_in,
   input wire logic wr_valid_in,
   input wire logic [31:0] wr_addr_in,
   input wire logic [31:0] wr_data_in,
   output logic wr_ready_out,
   output logic [31:0] words_out
);
   logic [31:0] mem [logic [31:0]];
   // store taken words; ready redrawn after each edge to stall at random
   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         wr_ready_out <= 1'b0;
         words_out <= 32'h0;
      end else begin
         if (wr_valid_in && wr_ready_out) begin
            mem[wr_addr_in] = wr_data_in;
            words_out <= words_out + 32'h1;
         end
         wr_ready_out <= ($urandom() % 100) < ready_pct_in;
      end
   end
endmodule // pcp_mem_model
`default_nettype wire

// [sim/pcp_pipeline_checker.sv]
`timescale 1ns/100ps
`default_nettype none
// ********
// port checker
// ********
module pcp_pipeline_checker (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire pcp_pkg::pcp_format_t format_in,
   input wire logic core_reset_in,
   input wire logic mem_wr_ready_in,
   input wire pcp_pkg::pcp_sync_t sync_out,
   input wire logic mem_wr_valid_out,
   input wire logic [31:0] mem_wr_addr_out,
   input wire logic [31:0] mem_wr_data_out,
   input wire logic mem_wr_last_out,
   input wire logic frame_done_out
);
   import pcp_pkg::*;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   logic take;
   logic cont_q;
   logic [31:0] next_q;
   logic [12:0] hs_cnt_q;
   logic [12:0] hs_exp;
   logic hs_ok_q;
   pcp_format_t fmt_seen_q;
   // take seen this cycle
   assign take = mem_wr_valid_out && mem_wr_ready_in;
   // expected next address; its continuity flag clears on core reset, whose restart is loose
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cont_q <= 1'b0;
         next_q <= 32'h0;
      end else if (core_reset_in) begin
         cont_q <= 1'b0;
      end else if (take) begin
         cont_q <= !mem_wr_last_out;
         next_q <= mem_wr_addr_out + 32'h4;
      end
   end
   // hsync width; only trusted from a rise under a steady format
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         hs_cnt_q <= 13'h0;
         hs_ok_q <= 1'b0;
         fmt_seen_q <= PCP_FMT_720P60;
      end else begin
         hs_cnt_q <= sync_out.hsync ? hs_cnt_q + 13'h1 : 13'h0;
         fmt_seen_q <= format_in;
         if (format_in != fmt_seen_q) hs_ok_q <= 1'b0;
         else if (sync_out.hsync && hs_cnt_q == 13'h0) hs_ok_q <= 1'b1;
      end
   end
   // beats of hsync per format
   assign hs_exp = (fmt_seen_q == PCP_FMT_720P60) ? 13'h014 :
      (fmt_seen_q == PCP_FMT_1080P60) ? 13'h016 : 13'h02C;
   active_blank_a: assert property (
      sync_out.active |-> !sync_out.hblank && !sync_out.vblank)
      else $error("active during blanking");
   hsync_blank_a: assert property (
      sync_out.hsync |-> sync_out.hblank) else $error("hsync outside hblank");
   vsync_blank_a: assert property (
      sync_out.vsync |-> sync_out.vblank) else $error("vsync outside vblank");
   hsync_width_a: assert property (
      $fell(sync_out.hsync) && hs_ok_q |-> hs_cnt_q == hs_exp)
      else $error("hsync width wrong");
   valid_hold_a: assert property (
      mem_wr_valid_out && !mem_wr_ready_in && !core_reset_in |=>
      mem_wr_valid_out && $stable(mem_wr_addr_out) &&
      $stable(mem_wr_data_out) && $stable(mem_wr_last_out))
      else $error("write word changed while stalled");
   addr_step_a: assert property (
      mem_wr_valid_out && cont_q && !core_reset_in |->
      mem_wr_addr_out == next_q) else $error("address step wrong");
   done_pulse_a: assert property (
      take && mem_wr_last_out && !core_reset_in |=> frame_done_out)
      else $error("frame done missing");
   done_cause_a: assert property (
      frame_done_out |-> $past(take && mem_wr_last_out) ##1 !frame_done_out)
      else $error("frame done without last word");
   cover property (take && !$past(mem_wr_ready_in));
   cover property ($rose(sync_out.hsync));
   cover property (frame_done_out);
endmodule // pcp_pipeline_checker
bind pcp_pipeline pcp_pipeline_checker chk_u (.clk_in(clk_in),
   .reset_in(reset_in), .format_in(format_in), .core_reset_in(core_reset_in),
   .mem_wr_ready_in(mem_wr_ready_in), .sync_out(sync_out),
   .mem_wr_valid_out(mem_wr_valid_out), .mem_wr_addr_out(mem_wr_addr_out),
   .mem_wr_data_out(mem_wr_data_out), .mem_wr_last_out(mem_wr_last_out),
   .frame_done_out(frame_done_out));
`default_nettype wire

// [sim/test_pattern_capture_pipeline.sv]
`timescale 1ns/100ps
`default_nettype none
// ********
// pipeline bench
// ********
module test_pattern_capture_pipeline;
   import pcp_pkg::*;
   localparam int LIMIT = 40000;
   logic clk_in, reset_in, core_reset_in, rdy, vld, last, done;
   pcp_format_t fmt;
   pcp_pattern_t pat;
   pcp_sync_t sync_out;
   logic [31:0] base, words, a, d, addr, data;
   logic [19:0] clk_khz;
   logic [6:0] pct;
   logic [47:0] px;
   logic [12:0] x;
   int n_mismatch, checks, cyc, act, on, blk, fp, hs;
   pcp_pipeline dut_u (.clk_in(clk_in), .reset_in(reset_in), .format_in(fmt),
      .pattern_in(pat), .core_reset_in(core_reset_in), .frame_base_in(base),
      .mem_wr_ready_in(rdy), .sync_out(sync_out), .pix_clk_khz_out(clk_khz),
      .mem_wr_valid_out(vld), .mem_wr_addr_out(addr), .mem_wr_data_out(data),
      .mem_wr_last_out(last), .frame_done_out(done));
   pcp_mem_model mem_u (.clk_in(clk_in), .reset_in(reset_in),
      .ready_pct_in(pct), .wr_valid_in(vld), .wr_addr_in(addr),
      .wr_data_in(data), .wr_ready_out(rdy), .words_out(words));
   // 10 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // hang guard
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen,
            exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // requested pixel clock in kHz
   function automatic logic [31:0] clk_exp(input int f);
      case (f)
         0: return 32'h1220A;
         1: return 32'h24414;
         2: return 32'h48828;
         default: return 32'h91050;
      endcase
   endfunction
   // active, front porch, sync, back porch in pixels
   function automatic logic [47:0] line_px(input int f);
      case (f)
         0: return {12'h500, 12'h06E, 12'h028, 12'h0DC};
         1: return {12'h780, 12'h058, 12'h02C, 12'h094};
         default: return {12'hF00, 12'h0B0, 12'h058, 12'h128};
      endcase
   endfunction
   // word for x=4,5 on line 0 of frame 0; bars and box both show white
   function automatic logic [31:0] first_word(input int p);
      case (p)
         0: return 32'h80EB80EB;
         1: return 32'h80008000;
         2: return 32'h80058004;
         default: return 32'h80EB80EB;
      endcase
   endfunction
   task automatic wait_blank(input logic v);
      for (int i = 0; i < 5000 && sync_out.hblank !== v; i++) @(negedge clk_in);
   endtask
   // one whole line from the end of hblank, counted in beats
   task automatic measure();
      act = 0;
      on = 0;
      blk = 0;
      fp = 0;
      hs = 0;
      wait_blank(1'b1);
      wait_blank(1'b0);
      while (sync_out.hblank === 1'b0 && act < 5000) begin
         act++;
         if (sync_out.active === 1'b1) on++;
         @(negedge clk_in);
      end
      while (sync_out.hblank === 1'b1 && blk < 5000) begin
         blk++;
         if (sync_out.hsync === 1'b1) hs++;
         else if (hs == 0) fp++;
         @(negedge clk_in);
      end
   endtask
   // main sequence; inputs move on the falling edge
   initial begin
      void'($urandom(7));
      reset_in = 1'b1;
      core_reset_in = 1'b0;
      fmt = PCP_FMT_720P60;
      pat = PCP_PAT_RAMP;
      base = $urandom() & 32'h0FFFFF00;
      pct = 7'h4B;
      repeat (5) @(negedge clk_in);
      check({12'h000, clk_khz}, 32'h1220A);
      check({31'h0, vld | done}, 32'h0);
      reset_in = 1'b0;
      // ramp words under random stalls: none lost, layout kept
      for (int i = 0; i < 3000 && words < 32'h2BC; i++) @(negedge clk_in);
      for (int k = 0; k < 700; k++) begin
         a = base + 32'(4 * k);
         x = 13'(2 * (k % 640));
         d = mem_u.mem[a];
         check(d, {8'h80, x[7:0] + 8'h1, 8'h80, x[7:0]});
      end
      // long stall freezes raster and the held word
      pct = 7'h00;
      repeat (200) @(negedge clk_in);
      d = {27'h0, sync_out};
      a = addr;
      repeat (50) @(negedge clk_in);
      check({27'h0, sync_out}, d);
      check(addr, a);
      check({31'h0, vld}, 32'h1);
      check({31'h0, last}, 32'h0);
      // every format and pattern, cores held in reset across the change
      pct = 7'h64;
      for (int f = 0; f < 4; f++) begin
         core_reset_in = 1'b1;
         fmt = pcp_format_t'(f);
         pat = pcp_pattern_t'(3 - f);
         repeat (3) @(negedge clk_in);
         check({12'h000, clk_khz}, clk_exp(f));
         core_reset_in = 1'b0;
         // first word after a restart carries pixels 4 and 5 of line 0
         for (int i = 0; i < 20 && vld !== 1'b1; i++) @(negedge clk_in);
         check({31'h0, vld}, 32'h1);
         if (f > 0) check(data, first_word(3 - f));
         measure();
         px = line_px(f);
         check(32'(act), 32'(px[47:36] >> 1));
         check(32'(on), 32'(act));
         check(32'(blk), 32'((px[35:24] + px[23:12] + px[11:0]) >> 1));
         check(32'(fp), 32'(px[35:24] >> 1));
         check(32'(hs), 32'(px[23:12] >> 1));
      end
      close_out();
   end
endmodule // test_pattern_capture_pipeline
`default_nettype wire
